/* File: hdl/sdci_card.sv */
// Card-side initialisation, mode choice and bus width front end
`include "sdci_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module sdci_card #(
	parameter logic [127:0] CID_VALUE  = `SDCI_CID_RESET,  // Arbitrary identity
	parameter logic [127:0] CSD_VALUE  = `SDCI_CSD_RESET,
	parameter logic [3:0]   PWRUP_POLL = `SDCI_PWRUP_POLLS
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        sd_clk_pin,
	input  wire logic        cmd_in,
	output logic             cmd_out,
	output logic             cmd_oe,
	input  wire logic [3:0]  dat_in,
	output logic [3:0]       dat_out,
	output logic [3:0]       dat_oe,
	output logic             dat3_pullup_en,
	output logic             spi_mode,
	output logic             wide_bus,
	output sdci_pkg::sdci_state_t card_state
);
	import sdci_pkg::*;

	logic [1:0]  pin_sync;           // Synced cmd and clock
	logic [3:0]  dat_sync;           // Synced data lines
	logic        sck_rise;           // Host clock rising edge
	logic        sck_fall;           // Host clock falling edge
	logic [3:0]  s_raw;              // Synchroniser outputs

	// Bring host clock, cmd and dat3 into our domain
	sdci_sync #(.W(4)) u_sync (
		.clk      (clk),
		.rst      (rst),
		.async_in ({dat_in[3], dat_in[0], cmd_in, sd_clk_pin}),
		.sync_out (s_raw),
		.rise_out (sck_rise),
		.fall_out (sck_fall)
	);
	assign pin_sync = s_raw[1:0];
	assign dat_sync = {s_raw[3], 2'b00, s_raw[2]};

	// Received command shift state
	logic [47:0] rx_q;               // Command shift register
	logic [5:0]  rx_cnt_q;           // Bits received in frame
	logic        rx_busy_q;          // Frame in progress
	logic        app_q;              // Previous command was APP
	logic [3:0]  poll_q;             // ACMD41 polls seen
	logic        pwr_done_q;         // Power-up finished
	logic [15:0] rca_q;              // Published address
	logic [15:0] lfsr_q;             // Address generator
	sdci_state_t state_q;
	logic        spi_q;
	logic        wide_q;
	logic        pull_q;
	// Response shift state
	logic [135:0] tx_q;              // Response shift register
	logic [7:0]   tx_cnt_q;          // Bits left to send
	logic         cmd_out_q, cmd_oe_q;

	// Decoded command fields
	wire        cmd_bit    = pin_sync[1];
	wire        frame_done = rx_busy_q && (rx_cnt_q == 6'd47) && sck_rise;
	wire [47:0] frame      = {rx_q[46:0], cmd_bit};
	wire [5:0]  idx        = frame[45:40];
	wire [31:0] arg        = frame[39:8];
	wire        framed_ok  = ~frame[47] & frame[46] & frame[0];
	wire        addressed  = (arg[31:16] == rca_q);
	wire        take       = frame_done && framed_ok && (tx_cnt_q == 8'd0);
	wire        is_app     = app_q && (idx != `SDCI_CMD_APP);

	// Legality and response selection per state
	logic       legal;
	sdci_rsp_t  rsp_kind;
	logic [127:0] rsp_body;
	always_comb begin
		legal    = 1'b0;
		rsp_kind = SDCI_RSP_NONE;
		rsp_body = '0;
		if (idx == `SDCI_CMD_GO_IDLE) begin
			legal = 1'b1;
		end else if (idx == `SDCI_CMD_APP) begin
			legal    = (state_q != SDCI_READY) && (state_q != SDCI_IDENT);
			rsp_kind = SDCI_RSP_SHORT;
		end else if (is_app && idx == `SDCI_CMD_OP_COND && state_q == SDCI_IDLE) begin
			legal    = 1'b1;
			rsp_kind = SDCI_RSP_SHORT;
			rsp_body = {96'h0, pwr_done_q, 7'h00, 24'h0} | {96'h0, `SDCI_OCR_WINDOW};
		end else if (idx == `SDCI_CMD_ALL_CID && state_q == SDCI_READY) begin
			legal    = 1'b1;
			rsp_kind = SDCI_RSP_LONG;
			rsp_body = CID_VALUE;
		end else if (idx == `SDCI_CMD_REL_ADDR &&
		             (state_q == SDCI_IDENT || state_q == SDCI_STBY)) begin
			legal    = 1'b1;
			rsp_kind = SDCI_RSP_SHORT;
			rsp_body = {96'h0, lfsr_q, 16'h0};
		end else if (idx == `SDCI_CMD_SELECT &&
		             (state_q == SDCI_STBY || state_q == SDCI_TRAN)) begin
			legal    = 1'b1;
			rsp_kind = addressed ? SDCI_RSP_SHORT : SDCI_RSP_NONE;
		end else if ((idx == `SDCI_CMD_SEND_CSD || idx == `SDCI_CMD_SEND_CID) &&
		             state_q == SDCI_STBY && addressed) begin
			legal    = 1'b1;
			rsp_kind = SDCI_RSP_LONG;
			rsp_body = (idx == `SDCI_CMD_SEND_CSD) ? CSD_VALUE : CID_VALUE;
		end else if (is_app && state_q == SDCI_TRAN &&
		             (idx == `SDCI_CMD_BUS_WIDTH || idx == `SDCI_CMD_SD_STATUS ||
		              idx == `SDCI_CMD_CARD_DET)) begin
			legal    = 1'b1;
			rsp_kind = SDCI_RSP_SHORT;                                // Card type reads zero
		end
	end

	// Response framing: start 0, direction 0, body, stop 1
	wire [135:0] short_frame = {2'b00, idx, rsp_body[31:0], 7'h7F, 1'b1, 88'h0};
	wire [135:0] long_frame  = {2'b00, 6'h3F, rsp_body[127:1], 1'b1};

	// Command receiver, samples on host clock rise
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_q      <= '0;
			rx_cnt_q  <= '0;
			rx_busy_q <= 1'b0;
		end else if (sck_rise) begin
			rx_q <= frame;
			if (!rx_busy_q) begin
				rx_busy_q <= ~cmd_bit && (tx_cnt_q == 8'd0);
				rx_cnt_q  <= 6'd1;
			end else if (rx_cnt_q == 6'd47) begin
				rx_busy_q <= 1'b0;
			end else begin
				rx_cnt_q <= rx_cnt_q + 6'd1;
			end
		end
	end

	// Card state machine and mode latches
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q    <= SDCI_IDLE;
			spi_q      <= 1'b0;
			wide_q     <= 1'b0;
			pull_q     <= 1'b1;
			app_q      <= 1'b0;
			poll_q     <= '0;
			pwr_done_q <= 1'b0;
			rca_q      <= '0;
			lfsr_q     <= `SDCI_RCA_SEED;
		end else begin
			lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
			if (take && legal) begin
				app_q <= (idx == `SDCI_CMD_APP);
				if (idx == `SDCI_CMD_GO_IDLE) begin
					state_q    <= SDCI_IDLE;
					spi_q      <= ~dat_sync[3];
					wide_q     <= 1'b0;
					pull_q     <= 1'b1;
					poll_q     <= '0;
					pwr_done_q <= 1'b0;
					rca_q      <= '0;
				end else if (is_app && idx == `SDCI_CMD_OP_COND) begin
					if (arg[23:15] != 9'h0) begin
						if (poll_q == PWRUP_POLL) begin
							pwr_done_q <= 1'b1;
							state_q    <= pwr_done_q ? SDCI_READY : SDCI_IDLE;
						end else begin
							poll_q <= poll_q + 4'h1;
						end
					end
				end else if (idx == `SDCI_CMD_ALL_CID) begin
					state_q <= SDCI_IDENT;
				end else if (idx == `SDCI_CMD_REL_ADDR) begin
					rca_q   <= (lfsr_q == 16'h0) ? 16'h0001 : lfsr_q;
					state_q <= SDCI_STBY;
				end else if (idx == `SDCI_CMD_SELECT) begin
					if (addressed)
						state_q <= (state_q == SDCI_STBY) ? SDCI_TRAN : SDCI_STBY;
					else
						state_q <= SDCI_STBY;
				end else if (is_app && idx == `SDCI_CMD_BUS_WIDTH) begin
					wide_q <= (arg[1:0] == 2'b10);
				end else if (is_app && idx == `SDCI_CMD_CARD_DET) begin
					pull_q <= arg[0];
				end
			end else if (take) begin
				app_q <= 1'b0;
			end
		end
	end

	// Response transmitter, drives on host clock fall after a command
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_q      <= '0;
			tx_cnt_q  <= '0;
			cmd_out_q <= 1'b1;
			cmd_oe_q  <= 1'b0;
		end else if (take && legal && rsp_kind != SDCI_RSP_NONE) begin
			tx_q     <= (rsp_kind == SDCI_RSP_LONG) ? long_frame : short_frame;
			tx_cnt_q <= (rsp_kind == SDCI_RSP_LONG) ?
			            8'(`SDCI_RSP_LONG_BITS) : 8'(`SDCI_RSP_SHORT_BITS);
		end else if (sck_fall) begin
			if (tx_cnt_q != 8'd0) begin
				cmd_out_q <= tx_q[135];
				cmd_oe_q  <= 1'b1;
				tx_q      <= {tx_q[134:0], 1'b1};
				tx_cnt_q  <= tx_cnt_q - 8'd1;
			end else begin
				cmd_out_q <= 1'b1;
				cmd_oe_q  <= 1'b0;
			end
		end
	end

	// Pin drivers: SPI puts responses on dat0, SD on cmd
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmd_out <= 1'b1;
			cmd_oe  <= 1'b0;
			dat_out <= 4'hF;
			dat_oe  <= 4'h0;
		end else begin
			cmd_out <= cmd_out_q;
			cmd_oe  <= cmd_oe_q & ~spi_q;
			dat_out <= {3'h7, cmd_out_q};
			dat_oe  <= {3'h0, cmd_oe_q & spi_q};
		end
	end

	// Status outputs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dat3_pullup_en <= 1'b1;
			spi_mode       <= 1'b0;
			wide_bus       <= 1'b0;
			card_state     <= SDCI_IDLE;
		end else begin
			dat3_pullup_en <= pull_q;
			spi_mode       <= spi_q;
			wide_bus       <= wide_q & ~spi_q;
			card_state     <= state_q;
		end
	end

	// Assertions
	a_width_narrow: assert property (@(posedge clk) disable iff (rst)
		!wide_bus |-> dat_oe[3:1] == 3'h0) else $error("upper lines driven");
	a_pull_reset: assert property (@(posedge clk) disable iff (rst)
		(take && legal && idx == `SDCI_CMD_GO_IDLE) |-> ##2 dat3_pullup_en)
		else $error("pullup not restored");
	a_no_spurious: assert property (@(posedge clk) disable iff (rst)
		$rose(cmd_oe_q) |-> tx_cnt_q != 8'd0 || $past(tx_cnt_q) != 8'd0)
		else $error("response without command");
	a_rca_nonzero: assert property (@(posedge clk) disable iff (rst)
		(state_q == SDCI_STBY) |-> rca_q != 16'h0) else $error("zero address");
	a_illegal_hold: assert property (@(posedge clk) disable iff (rst)
		(take && !legal) |=> $stable(state_q) && $stable(spi_q))
		else $error("illegal changed state");
	a_mode_hold: assert property (@(posedge clk) disable iff (rst)
		!(take && legal && idx == `SDCI_CMD_GO_IDLE) |=> $stable(spi_q))
		else $error("mode changed");
	a_start_bit: assert property (@(posedge clk) disable iff (rst)
		$rose(cmd_oe_q) |-> !cmd_out_q) else $error("no start bit");
	a_ready_done: assert property (@(posedge clk) disable iff (rst)
		(state_q == SDCI_READY) |-> pwr_done_q) else $error("ready while busy");
	a_spi_cmd_quiet: assert property (@(posedge clk) disable iff (rst)
		spi_mode |-> ##1 !cmd_oe || !spi_q) else $error("cmd driven in spi");
endmodule
`default_nettype wire

/* File: hdl/sdci_defs.svh */
// Constants for the card front end: commands, field positions, resets, timing
`ifndef SDCI_DEFS_SVH
`define SDCI_DEFS_SVH
`define SDCI_CMD_GO_IDLE     6'h00
`define SDCI_CMD_ALL_CID     6'h02
`define SDCI_CMD_REL_ADDR    6'h03
`define SDCI_CMD_BUS_WIDTH   6'h06
`define SDCI_CMD_SELECT      6'h07
`define SDCI_CMD_SEND_CSD    6'h09
`define SDCI_CMD_SEND_CID    6'h0A
`define SDCI_CMD_SD_STATUS   6'h0D
`define SDCI_CMD_OP_COND     6'h29
`define SDCI_CMD_CARD_DET    6'h2A
`define SDCI_CMD_APP         6'h37
`define SDCI_OCR_BUSY_BIT    31
`define SDCI_OCR_WINDOW      32'h00FF8000
`define SDCI_CMD_FRAME_BITS  48
`define SDCI_RSP_SHORT_BITS  48
`define SDCI_RSP_LONG_BITS   136
`define SDCI_RSP_CNT_W       8
`define SDCI_PWRUP_POLLS     4'h3
`define SDCI_RCA_SEED        16'hACE1
`define SDCI_CID_RESET       128'h0123456789ABCDEF0123456789ABCD01
`define SDCI_CSD_RESET       128'h400E0000000000000000000000000001
`endif

/* File: hdl/sdci_pkg.sv */
// Types shared by the card front end
package sdci_pkg;
	// Card state, Gray coded along identification path
	typedef enum logic [2:0] {
		SDCI_IDLE  = 3'h0,
		SDCI_READY = 3'h1,
		SDCI_IDENT = 3'h3,
		SDCI_STBY  = 3'h2,
		SDCI_TRAN  = 3'h6
	} sdci_state_t;
	// Response kinds
	typedef enum logic [1:0] {
		SDCI_RSP_NONE  = 2'h0,
		SDCI_RSP_SHORT = 2'h1,
		SDCI_RSP_LONG  = 2'h2
	} sdci_rsp_t;
endpackage

/* File: hdl/sdci_sync.sv */
// Two-flop synchroniser with edge finder for the host clock pin
`timescale 1ns/100ps
`default_nettype none
module sdci_sync #(
	parameter int W = 4
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] async_in,
	output logic [W-1:0]      sync_out,
	output logic              rise_out,
	output logic              fall_out
);
	logic [W-1:0] meta_q;  // First stage, read only by second
	logic [W-1:0] sync_q;  // Second stage
	logic         prev_q;  // Last value of bit 0 (clock)

	// Double flop every pin
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
			prev_q <= sync_q[0];
		end
	end
	assign sync_out = sync_q;
	assign rise_out = sync_q[0] & ~prev_q;
	assign fall_out = ~sync_q[0] & prev_q;
endmodule
`default_nettype wire

/* File: verif/sdci_host_model.sv */
// Host model: clocks each frame, sends commands, gathers responses
`timescale 1ns/100ps
`default_nettype none
module sdci_host_model (
	output logic      sd_clk,
	output logic      cmd_drv,
	output logic      cmd_en,
	input  wire logic rsp_line
);
	// Clock stands low and command line released between frames
	initial begin
		sd_clk = 1'b0;
		cmd_drv = 1'b1;
		cmd_en = 1'b0;
	end
	// One host clock; response sampled at the rise
	task automatic tick(output logic b);
		#80 sd_clk = 1'b1;
		b = rsp_line;
		#80 sd_clk = 1'b0;
	endtask
	// Over 74 dummy clocks before the first command
	task automatic warm();
		logic b;
		repeat (80) tick(b);
	endtask
	// Framed command out, then up to n response bits in
	task automatic send(input logic [5:0] i, input logic [31:0] a, input int n,
		output logic [135:0] r, output logic got);
		logic [47:0] f;
		logic b;
		int k;
		f = {2'b01, i, a, 8'hFF};
		r = '0;
		got = 1'b0;
		cmd_en = 1'b1;
		for (k = 47; k >= 0; k--) begin
			cmd_drv = f[k];
			tick(b);
		end
		// Released line floats high through the pull-up
		cmd_en = 1'b0;
		cmd_drv = 1'b1;
		// Silence within the timeout means no card answer
		for (k = 0; k < 8 && !got; k++) begin
			tick(b);
			got = !b;
		end
		if (got) begin
			for (k = 1; k < n; k++) begin
				tick(b);
				r = {r[134:0], b};
			end
		end
		repeat (4) tick(b);
	endtask
endmodule
`default_nettype wire

/* File: verif/tb_sdci_card.sv */
// Bench for the card front end against the host model
`include "sdci_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_sdci_card;
	import sdci_pkg::*;
	localparam logic [3:0]   PP  = 4'h2;           // Shortened busy poll count
	localparam logic [127:0] CID = `SDCI_CID_RESET;
	localparam logic [127:0] CSD = `SDCI_CSD_RESET;
	logic clk, rst, sd_clk, h_cmd, h_en, dat3, spi_sel, got;
	logic cmd_out, cmd_oe, pu, spi, wide;
	logic [3:0] dat_out, dat_oe;
	logic [135:0] r;
	logic [15:0] rca;
	sdci_state_t st;
	int err_total, compares, k;
	wire cmd_w  = cmd_oe ? cmd_out : (h_en ? h_cmd : 1'b1);
	wire dat0_w = dat_oe[0] ? dat_out[0] : 1'b1;
	// One card, own command and data lines
	sdci_host_model h (.sd_clk(sd_clk), .cmd_drv(h_cmd), .cmd_en(h_en),
		.rsp_line(spi_sel ? dat0_w : cmd_w));
	sdci_card #(.PWRUP_POLL(PP)) DUT (.clk(clk), .rst(rst), .sd_clk_pin(sd_clk),
		.cmd_in(cmd_w), .cmd_out(cmd_out), .cmd_oe(cmd_oe),
		.dat_in({dat3, 2'b11, dat0_w}), .dat_out(dat_out), .dat_oe(dat_oe),
		.dat3_pullup_en(pu), .spi_mode(spi), .wide_bus(wide), .card_state(st));
	// System clock
	always #5 clk = ~clk;
	// Value comparison
	task automatic chk(input string n, input logic [135:0] e, input logic [135:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic rq(input logic [5:0] i, input logic [31:0] a, input int n);
		h.send(i, a, n, r, got);
	endtask
	// Application command: prefix then command
	task automatic ac(input logic [5:0] i, input logic [31:0] a);
		rq(6'h37, 32'h0, 48);
		rq(i, a, 48);
	endtask
	// Short response: start, direction, index, body, filler, stop
	task automatic sb(input logic [5:0] i, input logic [31:0] b);
		chk("answered", 1, got);
		chk("short", {2'b00, i, b, 8'hFF}, r[47:0]);
	endtask
	task automatic t_reset();
		chk("dat_oe", 0, dat_oe);
		chk("pullup", 1, pu);
		chk("wide", 0, wide);
		chk("state", SDCI_IDLE, st);
	endtask
	task automatic t_opcond();
		dat3 = 1'b1;
		rq(6'h00, 32'h0, 48);
		chk("spi", 0, spi);
		ac(6'h29, 32'h0);
		sb(6'h29, `SDCI_OCR_WINDOW);
		for (k = 1; k <= 8; k++) begin
			ac(6'h29, `SDCI_OCR_WINDOW);
			if (r[39] === 1'b1) break;
		end
		// Busy reads zero through PP + 1 voltage polls, ready on the next
		chk("polls", PP + 2, k);
		sb(6'h29, 32'h80000000 | `SDCI_OCR_WINDOW);
		chk("state", SDCI_READY, st);
	endtask
	task automatic t_illegal();
		rq(6'h37, 32'h0, 48);
		chk("no answer", 0, got);
		rq(6'h07, 32'h0, 48);
		chk("no answer", 0, got);
		chk("state", SDCI_READY, st);
	endtask
	task automatic t_ident();
		rq(6'h02, 32'h0, 136);
		chk("cid", {8'h3F, CID[127:1], 1'b1}, r);
		chk("state", SDCI_IDENT, st);
		rq(6'h03, 32'h0, 48);
		rca = r[39:24];
		sb(6'h03, {rca, 16'h0});
		chk("rca nonzero", 1, rca != 16'h0);
		chk("state", SDCI_STBY, st);
	endtask
	task automatic t_tran();
		rq(6'h07, {rca, 16'h0}, 48);
		sb(6'h07, 32'h0);
		chk("state", SDCI_TRAN, st);
		ac(6'h0D, 32'h0);
		sb(6'h0D, 32'h0);
		ac(6'h2A, 32'h0);
		chk("pullup", 0, pu);
		rq(6'h07, {rca, 16'h0}, 48);
		chk("state", SDCI_STBY, st);
		rq(6'h09, {rca, 16'h0}, 136);
		chk("csd", {8'h3F, CSD[127:1], 1'b1}, r);
		rq(6'h0A, {rca, 16'h0}, 136);
		chk("cid", {8'h3F, CID[127:1], 1'b1}, r);
		rq(6'h07, {rca, 16'h0}, 48);
		chk("wide", 0, wide);
		chk("dat_oe", 0, dat_oe);
		ac(6'h06, 32'h2);
		sb(6'h06, 32'h0);
		chk("wide", 1, wide);
	endtask
	task automatic t_spi();
		dat3 = 1'b0;
		spi_sel = 1'b1;
		rq(6'h00, 32'h0, 48);
		chk("spi", 1, spi);
		rq(6'h37, 32'h0, 48);
		sb(6'h37, 32'h0);
		chk("cmd_oe", 0, cmd_oe);
		dat3 = 1'b1;
		#2000;
		chk("spi", 1, spi);
		spi_sel = 1'b0;
		rq(6'h00, 32'h0, 48);
		chk("spi", 0, spi);
	endtask
	// Verdict and end of run
	task automatic final_report();
		if (err_total == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		dat3 = 1'b1;
		spi_sel = 1'b0;
		err_total = 0;
		compares = 0;
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		repeat (4) @(posedge clk);
		// Keep every later host edge just after a system clock edge
		#1;
		t_reset();
		h.warm();
		t_opcond();
		t_illegal();
		t_ident();
		t_tran();
		t_spi();
		final_report();
	end
	// Watchdog
	initial begin
		#900000;
		err_total++;
		final_report();
	end
endmodule
`default_nettype wire
